// *** design/sdc_config_regs.sv ***
// Purpose: Write-only configuration bank of a fractional-N synthesizer.
// Assumes: Host writes 32-bit words most significant bit first over a 3-wire port.
// Notes: Registers 1, 2, 3 are double buffered and applied on a register 0 write.
`timescale 1ns/1ns

// =============================================================
// Configuration register bank
// What this block does
// [R1] Low four bits pick the target register.
// [R2] Host writes zero to register 0 top.
// [R3] Register 0 write with bit 21 calibrates.
// [R4] Bit 21 clear keeps the current band.
// [R5] Host toggles calibration when changing frequency.
// [R6] Bit 20 picks prescaler, sets integer minimum.
// [R7] Host keeps integer within prescaler limits.
// [R8] Register 1 holds 24-bit main numerator.
// [R9] Host keeps numerator below main modulus.
// [R10] Aux numerator joins high and low parts.
// [R11] Host keeps aux numerator below aux modulus.
// [R12] Aux modulus joins high and low parts.
// [R13] Registers 1-3 apply on register 0 write.
// [R14] Host writes zero to register 3 top.
// [R15] Register 0 write resets modulator unless disabled.
// [R16] Resync applies only after programmed timeout.
// [R17] Host keeps modulator reset on for resync.
// [R18] Host selects divided feedback below 3400 MHz.
// [R19] Phase offset word shifts output phase.
// [R20] Word is 32 bits, captured at load.
module sdc_config_regs
  import sdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_enable,
  input wire logic pfd_tick,
  output logic [15:0] integer_divide,
  output logic prescaler_sel,
  output logic int_out_of_range,
  output logic [sdc_pkg::MFRAC_W-1:0] main_fraction_numerator,
  output logic [sdc_pkg::AUX_W-1:0] aux_fraction_numerator,
  output logic [sdc_pkg::AUX_W-1:0] aux_fraction_modulus,
  output logic [sdc_pkg::PHASE_W-1:0] phase_offset_word,
  output logic resync_enable,
  output logic vco_band_calibration,
  output logic modulator_reset,
  output logic resync_pulse
);
  // =============================================================
  // Pin synchronisers and word receiver
  logic sclk_s;
  logic sdata_s;
  logic load_s;
  logic [WORD_W-1:0] word;
  logic word_valid;

  sdc_sync u_sync_clk (.ref_clk(ref_clk), .reset(reset), .pin_in(serial_clk), .pin_sync(sclk_s));
  sdc_sync u_sync_dat (.ref_clk(ref_clk), .reset(reset), .pin_in(serial_data), .pin_sync(sdata_s));
  sdc_sync u_sync_ld (.ref_clk(ref_clk), .reset(reset), .pin_in(load_enable), .pin_sync(load_s));

  sdc_shifter u_shifter (
    .ref_clk(ref_clk),
    .reset(reset),
    .sclk_s(sclk_s),
    .sdata_s(sdata_s),
    .load_s(load_s),
    .word(word),
    .word_valid(word_valid)
  );

  // =============================================================
  // Address decode
  wire [3:0] sel = word[SEL_W-1:0];
  wire wr_r0 = word_valid && (sel == SEL_INT_CTRL); // R1 R20
  wire wr_r1 = word_valid && (sel == SEL_MAIN_FRAC); // R1
  wire wr_r2 = word_valid && (sel == SEL_AUX_LOW); // R1
  wire wr_r3 = word_valid && (sel == SEL_PHASE_CTRL); // R1
  wire wr_r12 = word_valid && (sel == SEL_RESYNC_TMO);
  wire wr_r13 = word_valid && (sel == SEL_AUX_HIGH);

  // =============================================================
  // Input buffers for double-buffered registers
  logic [MFRAC_W-1:0] mfrac_buf_q;
  logic [AUX_PART_W-1:0] aux_num_lo_buf_q;
  logic [AUX_PART_W-1:0] aux_mod_lo_buf_q;
  logic [AUX_PART_W-1:0] aux_num_hi_q;
  logic [AUX_PART_W-1:0] aux_mod_hi_q;
  logic mrst_dis_buf_q;
  logic resync_en_buf_q;
  logic [PHASE_W-1:0] phase_buf_q;
  logic [TMO_W-1:0] tmo_q;
  logic mrst_dis_q;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mfrac_buf_q <= '0;
      aux_num_lo_buf_q <= '0;
      aux_mod_lo_buf_q <= '0;
      aux_num_hi_q <= '0;
      aux_mod_hi_q <= '0;
      mrst_dis_buf_q <= 1'b0;
      resync_en_buf_q <= 1'b0;
      phase_buf_q <= '0;
      tmo_q <= '0;
    end else begin
      if (wr_r1) begin
        mfrac_buf_q <= word[MFRAC_LSB +: MFRAC_W]; // R8 R13
      end
      if (wr_r2) begin
        aux_num_lo_buf_q <= word[AUX_NUM_LO_LSB +: AUX_PART_W]; // R13
        aux_mod_lo_buf_q <= word[AUX_MOD_LO_LSB +: AUX_PART_W]; // R13
      end
      if (wr_r3) begin
        mrst_dis_buf_q <= word[MOD_RST_DIS_BIT]; // R13
        resync_en_buf_q <= word[RESYNC_EN_BIT]; // R13
        phase_buf_q <= word[PHASE_LSB +: PHASE_W]; // R13
      end
      if (wr_r12) begin
        tmo_q <= word[TMO_LSB +: TMO_W];
      end
      if (wr_r13) begin
        aux_num_hi_q <= word[AUX_NUM_HI_LSB +: AUX_PART_W];
        aux_mod_hi_q <= word[AUX_MOD_HI_LSB +: AUX_PART_W];
      end
    end
  end

  // =============================================================
  // Active registers, updated by a register 0 write
  wire [AUX_W-1:0] aux_num_join = {aux_num_hi_q, aux_num_lo_buf_q}; // R10
  wire [AUX_W-1:0] aux_mod_join = {aux_mod_hi_q, aux_mod_lo_buf_q}; // R12
  wire [15:0] int_field = word[INT_LSB +: INT_W];
  wire pre_field = word[PRESCALER_BIT];
  wire [15:0] int_min = pre_field ? INT_MIN_P89 : INT_MIN_P45;
  wire int_bad = (int_field < int_min) || (!pre_field && int_field > INT_MAX_P45);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      integer_divide <= '0;
      prescaler_sel <= 1'b0;
      int_out_of_range <= 1'b0;
      main_fraction_numerator <= '0;
      aux_fraction_numerator <= '0;
      aux_fraction_modulus <= '0;
      phase_offset_word <= '0;
      resync_enable <= 1'b0;
      mrst_dis_q <= 1'b0;
      vco_band_calibration <= 1'b0;
      modulator_reset <= 1'b0;
    end else begin
      vco_band_calibration <= 1'b0;
      modulator_reset <= 1'b0;
      if (wr_r0) begin
        integer_divide <= int_field;
        prescaler_sel <= pre_field; // R6
        int_out_of_range <= int_bad; // R6
        main_fraction_numerator <= mfrac_buf_q; // R13
        aux_fraction_numerator <= aux_num_join; // R10 R13
        aux_fraction_modulus <= aux_mod_join; // R12 R13
        phase_offset_word <= phase_buf_q; // R13 R19
        resync_enable <= resync_en_buf_q; // R13 R16
        mrst_dis_q <= mrst_dis_buf_q; // R13
        vco_band_calibration <= word[CAL_EN_BIT]; // R3 R4
        modulator_reset <= ~mrst_dis_buf_q; // R15
      end
    end
  end

  // =============================================================
  // Resync activation timeout, counted in phase detector ticks
  logic [TMO_W-1:0] tmo_cnt_q;
  logic tmo_run_q;
  wire tmo_done = tmo_run_q && pfd_tick && (tmo_cnt_q == '0);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tmo_cnt_q <= '0;
      tmo_run_q <= 1'b0;
      resync_pulse <= 1'b0;
    end else begin
      resync_pulse <= 1'b0;
      if (wr_r0) begin
        tmo_cnt_q <= tmo_q;
        tmo_run_q <= resync_en_buf_q; // R16
      end else if (tmo_run_q && pfd_tick) begin
        if (tmo_cnt_q == '0) begin
          tmo_run_q <= 1'b0;
          resync_pulse <= resync_enable; // R16
        end else begin
          tmo_cnt_q <= tmo_cnt_q - 1'b1;
        end
      end
    end
  end

  // =============================================================
  // Checks
  a_cal_follows_r0: assert property (@(posedge ref_clk) disable iff (reset) // R3
    vco_band_calibration |-> $past(wr_r0) && $past(word[CAL_EN_BIT]))
    else $error("Calibration without enabled register 0 write.");
  a_cal_when_enabled: assert property (@(posedge ref_clk) disable iff (reset) // R3
    (wr_r0 && word[CAL_EN_BIT]) |=> vco_band_calibration)
    else $error("Calibration missing after enabled register 0 write.");
  a_band_kept: assert property (@(posedge ref_clk) disable iff (reset) // R4
    (wr_r0 && !word[CAL_EN_BIT]) |=> !vco_band_calibration)
    else $error("Calibration started while disabled.");
  a_mod_reset: assert property (@(posedge ref_clk) disable iff (reset) // R15
    wr_r0 |=> (modulator_reset == !$past(mrst_dis_buf_q)))
    else $error("Modulator reset does not follow disable bit.");
  a_buffer_holds: assert property (@(posedge ref_clk) disable iff (reset) // R13
    (wr_r1 && !wr_r0) |=> $stable(main_fraction_numerator))
    else $error("Main numerator changed before register 0 write.");
  a_buffer_applies: assert property (@(posedge ref_clk) disable iff (reset) // R13 R19
    wr_r0 |=> (main_fraction_numerator == $past(mfrac_buf_q))
      && (phase_offset_word == $past(phase_buf_q)))
    else $error("Buffered data not applied on register 0 write.");
  a_aux_join: assert property (@(posedge ref_clk) disable iff (reset) // R10 R12
    wr_r0 |=> aux_fraction_numerator == {$past(aux_num_hi_q), $past(aux_num_lo_buf_q)}
      && aux_fraction_modulus == {$past(aux_mod_hi_q), $past(aux_mod_lo_buf_q)})
    else $error("Auxiliary fraction not joined correctly.");
  a_resync_gated: assert property (@(posedge ref_clk) disable iff (reset) // R16
    resync_pulse |-> resync_enable && $past(tmo_done))
    else $error("Resync pulse before timeout or while disabled.");
  a_int_minimum: assert property (@(posedge ref_clk) disable iff (reset) // R6
    (wr_r0 && pre_field && int_field < INT_MIN_P89) |=> int_out_of_range)
    else $error("Integer below prescaler minimum not flagged.");
  a_select_decode: assert property (@(posedge ref_clk) disable iff (reset) // R1 R20
    wr_r3 |=> phase_buf_q == $past(word[PHASE_LSB +: PHASE_W]))
    else $error("Register 3 word not captured.");

  // =============================================================
  // Checks on the input buffers
  // Every buffer takes its field from a word of its own select code only.
  a_main_capture: assert property (@(posedge ref_clk) disable iff (reset) // R1 R8
    wr_r1 |=> mfrac_buf_q == $past(word[MFRAC_LSB +: MFRAC_W]))
    else $error("Register 1 word not captured.");
  a_aux_low_capture: assert property (@(posedge ref_clk) disable iff (reset) // R1 R10 R12
    wr_r2 |=> aux_num_lo_buf_q == $past(word[AUX_NUM_LO_LSB +: AUX_PART_W])
      && aux_mod_lo_buf_q == $past(word[AUX_MOD_LO_LSB +: AUX_PART_W]))
    else $error("Register 2 word not captured.");
  a_aux_high_capture: assert property (@(posedge ref_clk) disable iff (reset) // R10 R12
    wr_r13 |=> aux_num_hi_q == $past(word[AUX_NUM_HI_LSB +: AUX_PART_W])
      && aux_mod_hi_q == $past(word[AUX_MOD_HI_LSB +: AUX_PART_W]))
    else $error("Register 13 word not captured.");
  a_ctrl_capture: assert property (@(posedge ref_clk) disable iff (reset) // R1 R15 R16
    wr_r3 |=> mrst_dis_buf_q == $past(word[MOD_RST_DIS_BIT])
      && resync_en_buf_q == $past(word[RESYNC_EN_BIT]))
    else $error("Register 3 control bits not captured.");
  a_tmo_capture: assert property (@(posedge ref_clk) disable iff (reset) // R16
    wr_r12 |=> tmo_q == $past(word[TMO_LSB +: TMO_W]))
    else $error("Register 12 timeout not captured.");

  // =============================================================
  // Checks on the active registers
  // A word that is refused or routed elsewhere must leave every active field alone.
  a_outputs_steady: assert property (@(posedge ref_clk) disable iff (reset) // R13
    !wr_r0 |=> $stable(integer_divide) && $stable(prescaler_sel)
      && $stable(main_fraction_numerator) && $stable(aux_fraction_numerator)
      && $stable(aux_fraction_modulus) && $stable(phase_offset_word)
      && $stable(resync_enable))
    else $error("Active field changed without a register 0 write.");
  a_int_applied: assert property (@(posedge ref_clk) disable iff (reset) // R6 R20
    wr_r0 |=> integer_divide == $past(int_field)
      && prescaler_sel == $past(pre_field))
    else $error("Integer or prescaler not applied on register 0 write.");
  a_int_low_p45: assert property (@(posedge ref_clk) disable iff (reset) // R6
    (wr_r0 && !pre_field && int_field < INT_MIN_P45) |=> int_out_of_range)
    else $error("Integer below 4/5 minimum not flagged.");
  a_int_legal_p89: assert property (@(posedge ref_clk) disable iff (reset) // R6
    (wr_r0 && pre_field && int_field >= INT_MIN_P89) |=> !int_out_of_range)
    else $error("Legal 8/9 integer flagged as out of range.");
  a_resync_applied: assert property (@(posedge ref_clk) disable iff (reset) // R13 R16
    wr_r0 |=> resync_enable == $past(resync_en_buf_q))
    else $error("Resync enable not applied on register 0 write.");
  a_mrst_when_enabled: assert property (@(posedge ref_clk) disable iff (reset) // R15
    (wr_r0 && !mrst_dis_buf_q) |=> modulator_reset)
    else $error("Modulator reset missing after register 0 write.");
  a_mrst_when_disabled: assert property (@(posedge ref_clk) disable iff (reset) // R15
    (wr_r0 && mrst_dis_buf_q) |=> !modulator_reset)
    else $error("Modulator reset issued while suppressed.");
  // Calibration and modulator reset are strobes; a level would retrigger the loop.
  a_cal_single: assert property (@(posedge ref_clk) disable iff (reset) // R3
    vco_band_calibration |=> !vco_band_calibration)
    else $error("Calibration strobe longer than one cycle.");
  a_mrst_single: assert property (@(posedge ref_clk) disable iff (reset) // R15
    modulator_reset |=> !modulator_reset)
    else $error("Modulator reset strobe longer than one cycle.");

  // =============================================================
  // Checks on the resync timeout
  // The count reloads on every register 0 write, so a new frequency restarts the wait.
  a_tmo_load: assert property (@(posedge ref_clk) disable iff (reset) // R16
    wr_r0 |=> tmo_cnt_q == $past(tmo_q)
      && tmo_run_q == $past(resync_en_buf_q))
    else $error("Timeout not reloaded on register 0 write.");
  a_tmo_count: assert property (@(posedge ref_clk) disable iff (reset) // R16
    (tmo_run_q && pfd_tick && !wr_r0 && tmo_cnt_q != '0) |=> tmo_cnt_q == $past(tmo_cnt_q) - 1'b1)
    else $error("Timeout count did not step on a detector tick.");
  // A write in the expiry cycle wins, so the pulse is only promised without one.
  a_resync_fires: assert property (@(posedge ref_clk) disable iff (reset) // R16
    (tmo_done && !wr_r0 && resync_enable) |=> resync_pulse)
    else $error("Resync pulse missing after timeout expiry.");
endmodule : sdc_config_regs

// *** design/sdc_pkg.sv ***
// Purpose: Shared constants for the synthesizer divider configuration bank.
// Assumes: 32-bit programming words, register select in the low four bits.
// Notes: Register 12 and 13 selects follow the same four-bit code space.
package sdc_pkg;
  localparam int WORD_W = 32;
  localparam int SEL_W = 4;
  localparam logic [3:0] SEL_INT_CTRL = 4'h0;
  localparam logic [3:0] SEL_MAIN_FRAC = 4'h1;
  localparam logic [3:0] SEL_AUX_LOW = 4'h2;
  localparam logic [3:0] SEL_PHASE_CTRL = 4'h3;
  localparam logic [3:0] SEL_RESYNC_TMO = 4'hc;
  localparam logic [3:0] SEL_AUX_HIGH = 4'hd;
  // Register 0 fields.
  localparam int CAL_EN_BIT = 21;
  localparam int PRESCALER_BIT = 20;
  localparam int INT_LSB = 4;
  localparam int INT_W = 16;
  // Register 1 fields.
  localparam int MFRAC_LSB = 4;
  localparam int MFRAC_W = 24;
  // Register 2 and 13 fields.
  localparam int AUX_PART_W = 14;
  localparam int AUX_NUM_LO_LSB = 18;
  localparam int AUX_MOD_LO_LSB = 4;
  localparam int AUX_NUM_HI_LSB = 18;
  localparam int AUX_MOD_HI_LSB = 4;
  localparam int AUX_W = 28;
  // Register 3 fields.
  localparam int MOD_RST_DIS_BIT = 30;
  localparam int RESYNC_EN_BIT = 29;
  localparam int PHASE_LSB = 4;
  localparam int PHASE_W = 24;
  // Register 12 fields.
  localparam int TMO_LSB = 12;
  localparam int TMO_W = 20;
  // Prescaler integer limits.
  localparam logic [15:0] INT_MIN_P45 = 16'h0017;
  localparam logic [15:0] INT_MAX_P45 = 16'h7fff;
  localparam logic [15:0] INT_MIN_P89 = 16'h004b;
endpackage : sdc_pkg

// *** design/sdc_shifter.sv ***
// Purpose: Serial word receiver for the 3-wire programming port.
// Assumes: Data is sampled on rising serial clock, load enable high ends a word.
// Notes: Inputs are already synchronised; a word is taken only after 32 bits.
`timescale 1ns/1ns
module sdc_shifter
  import sdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sclk_s,
  input wire logic sdata_s,
  input wire logic load_s,
  output logic [sdc_pkg::WORD_W-1:0] word,
  output logic word_valid
);
  logic sclk_prev_q;
  logic load_prev_q;
  logic [WORD_W-1:0] shift_q;
  logic [5:0] count_q;
  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire load_rise = load_s & ~load_prev_q;
  wire full = (count_q >= 6'h20);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclk_prev_q <= 1'b0;
      load_prev_q <= 1'b0;
      shift_q <= '0;
      count_q <= 6'h00;
      word <= '0;
      word_valid <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      load_prev_q <= load_s;
      word_valid <= 1'b0;
      if (load_rise) begin
        count_q <= 6'h00;
        if (full) begin
          word <= shift_q;
          word_valid <= 1'b1;
        end
      end else if (sclk_rise && !load_s) begin
        shift_q <= {shift_q[WORD_W-2:0], sdata_s};
        if (!full) begin
          count_q <= count_q + 6'h01;
        end
      end
    end
  end
endmodule : sdc_shifter

// *** design/sdc_sync.sv ***
// Purpose: Two flip-flop synchroniser for one pin level.
// Assumes: Input is asynchronous to ref_clk.
// Notes: Only the second stage may be read.
`timescale 1ns/1ns
module sdc_sync (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic pin_in,
  output logic pin_sync
);
  logic stage1_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stage1_q <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      stage1_q <= pin_in;
      pin_sync <= stage1_q;
    end
  end
endmodule : sdc_sync

// *** test/sdc_config_regs_tb.sv ***
// Purpose: Self-checking bench for the configuration register bank.
// Assumes: The host model shifts words over the 3-wire port, all whole except one cut to 20 bits.
// Notes: The writer queues expected states; a negedge monitor checks each change.
`timescale 1ns/1ns
module sdc_config_regs_tb;
  import sdc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic pfd_tick = 1'b0;
  logic serial_clk, serial_data, load_enable;
  logic [15:0] integer_divide;
  logic prescaler_sel, int_out_of_range, resync_enable;
  logic vco_band_calibration, modulator_reset, resync_pulse;
  logic [MFRAC_W-1:0] main_fraction_numerator;
  logic [AUX_W-1:0] aux_fraction_numerator, aux_fraction_modulus;
  logic [PHASE_W-1:0] phase_offset_word;
  logic [31:0] b1 = '0, b2 = '0, b3 = '0, r12 = '0, r13 = '0;
  logic [124:0] snap;
  logic [124:0] notes[$];
  logic [122:0] last_data = '0;
  int rq[$];
  int miscompares = 0, tests_run = 0, ticks = 0, cyc = 0;

  always #5 ref_clk = ~ref_clk;

  assign snap = {integer_divide, prescaler_sel, int_out_of_range, main_fraction_numerator,
    aux_fraction_numerator, aux_fraction_modulus, phase_offset_word, resync_enable,
    vco_band_calibration, modulator_reset};

  sdc_host_model u_sdc_host_model (.ref_clk(ref_clk), .serial_clk(serial_clk),
    .serial_data(serial_data), .load_enable(load_enable));

  sdc_config_regs u_sdc_config_regs (.ref_clk(ref_clk), .reset(reset),
    .serial_clk(serial_clk), .serial_data(serial_data), .load_enable(load_enable),
    .pfd_tick(pfd_tick), .integer_divide(integer_divide), .prescaler_sel(prescaler_sel),
    .int_out_of_range(int_out_of_range), .main_fraction_numerator(main_fraction_numerator),
    .aux_fraction_numerator(aux_fraction_numerator),
    .aux_fraction_modulus(aux_fraction_modulus), .phase_offset_word(phase_offset_word),
    .resync_enable(resync_enable), .vco_band_calibration(vco_band_calibration),
    .modulator_reset(modulator_reset), .resync_pulse(resync_pulse));

  // =============================================================
  // Checking and closing
  task automatic compare_snap(input logic [124:0] e, input logic [124:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : compare_snap

  // The timeout counter loads with the outputs; the tick count may be off by one either way.
  task automatic compare_ticks(input int e, input int g);
    tests_run++;
    if (g < e - 1 || g > e + 1) begin
      miscompares++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : compare_ticks

  task automatic complete_run;
    $display("Counts: tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // Any output change without a queued note is a mismatch.
  always @(negedge ref_clk) begin
    if (!reset) begin
      if (pfd_tick) ticks++;
      if (snap[124:2] !== last_data || snap[1] === 1'b1 || snap[0] === 1'b1) begin
        ticks = 0;
        last_data = snap[124:2];
        if (notes.size() == 0) compare_snap('1, snap);
        else compare_snap(notes.pop_front(), snap);
      end
      if (resync_pulse !== 1'b0) begin
        if (rq.size() == 0) compare_ticks(-9, ticks);
        else compare_ticks(rq.pop_front(), ticks);
      end
    end
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    pfd_tick <= (cyc % 4 == 0);
    if (cyc == 60000) begin
      miscompares++;
      complete_run();
    end
  end

  // =============================================================
  // Writer with shadow copy of the buffered registers
  task automatic wr(input logic [31:0] w);
    logic oor;
    oor = w[20] ? (w[19:4] < INT_MIN_P89) : (w[19:4] < INT_MIN_P45 || w[19:4] > INT_MAX_P45);
    case (w[3:0])
      SEL_MAIN_FRAC: b1 = w;
      SEL_AUX_LOW: b2 = w;
      SEL_PHASE_CTRL: b3 = w;
      SEL_RESYNC_TMO: r12 = w;
      SEL_AUX_HIGH: r13 = w;
      SEL_INT_CTRL: begin
        notes.push_back({w[19:4], w[20], oor, b1[27:4], r13[31:18], b2[31:18], r13[17:4],
          b2[17:4], b3[27:4], b3[29], w[21], ~b3[30]});
        if (b3[29]) rq.push_back(int'(r12[31:12]));
      end
      default: ;
    endcase
    u_sdc_host_model.send_bits(w, 32);
  endtask : wr

  initial begin
    logic [15:0] ints [8];
    ints = '{16'h0017, 16'h0016, 16'h7fff, 16'h8000, 16'h004b, 16'h004a, 16'hffff, 16'h0064};
    void'($urandom(32'h07a46922));
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(negedge ref_clk);
    compare_snap('0, snap);
    for (int i = 0; i < 8; i++) begin
      wr({4'h0, 24'($urandom()), SEL_MAIN_FRAC});
      wr({28'($urandom()), SEL_AUX_LOW});
      wr({1'b0, 13'($urandom()), 1'b1, 13'($urandom()), SEL_AUX_HIGH});
      wr({1'b0, i[0], 2'b00, 24'($urandom()), SEL_PHASE_CTRL});
      wr({10'h0, 1'b1, 1'(i >= 4 && i < 7), ints[i], SEL_INT_CTRL});
    end
    wr({28'($urandom()), 4'h5});
    wr({4'h0, 24'h123456, SEL_MAIN_FRAC});
    u_sdc_host_model.send_bits({10'h0, 1'b1, 1'b0, 16'h0100, SEL_INT_CTRL}, 20);
    repeat (50) @(posedge ref_clk);
    wr({20'd20, 8'h00, SEL_RESYNC_TMO});
    wr({4'b0010, 24'($urandom()), SEL_PHASE_CTRL});
    wr({10'h0, 1'b1, 1'b0, 16'h0200, SEL_INT_CTRL});
    repeat (200) @(posedge ref_clk);
    wr({4'b0000, 24'hffffff, SEL_PHASE_CTRL});
    wr({10'h0, 1'b0, 1'b0, 16'h0200, SEL_INT_CTRL});
    repeat (200) @(posedge ref_clk);
    if (notes.size() != 0 || rq.size() != 0) miscompares++;
    complete_run();
  end
endmodule : sdc_config_regs_tb

// *** test/sdc_host_model.sv ***
// Purpose: Host controller model for the 3-wire programming port.
// Assumes: Serial clock period of 16 ref_clk cycles, most significant bit first.
// Notes: Clock stands still between words; data shows the inverse of the last bit after.
`timescale 1ns/1ns
module sdc_host_model (
  input wire logic ref_clk,
  output logic serial_clk,
  output logic serial_data,
  output logic load_enable
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_enable = 1'b0;
  end

  // =============================================================
  // Word transfer
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_clk

  // Shifts the low n bits of w, then pulses the load line.
  task automatic send_bits(input logic [31:0] w, input int n);
    wait_clk(1);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data <= w[i];
      wait_clk(8);
      serial_clk <= 1'b1;
      wait_clk(8);
      serial_clk <= 1'b0;
    end
    serial_data <= ~w[0];
    wait_clk(4);
    load_enable <= 1'b1;
    wait_clk(4);
    load_enable <= 1'b0;
    wait_clk(8);
  endtask : send_bits
endmodule : sdc_host_model
